// ==== verilog/pdq_pkg.sv ====
// Purpose: Shared constants for the packet descriptor queue engine.
// Assumes: Descriptors are four aligned 32-bit words in system memory.
// Notes:   Flag bit positions sit in the upper half of word 3.
`default_nettype none

package pdq_pkg;
    localparam int unsigned PDQ_CHANNELS = 8;
    localparam int unsigned PDQ_CH_W = 3;
    localparam int unsigned PDQ_DESC_WORDS = 4;
    localparam logic [1:0] PDQ_W_NEXT = 2'h0;
    localparam logic [1:0] PDQ_W_BUF = 2'h1;
    localparam logic [1:0] PDQ_W_LEN = 2'h2;
    localparam logic [1:0] PDQ_W_FLAGS = 2'h3;
    localparam logic [31:0] PDQ_NULL_PTR = 32'h0000_0000;
    localparam logic [31:0] PDQ_WORD_STEP = 32'h0000_0004;
    localparam int unsigned PDQ_BIT_FIRST = 31;
    localparam int unsigned PDQ_BIT_LAST = 30;
    localparam int unsigned PDQ_BIT_HELD = 29;
    localparam int unsigned PDQ_BIT_LIST_END = 28;
    localparam int unsigned PDQ_HALF = 16;

    typedef enum logic [2:0] {
        PDQ_IDLE = 3'h0,
        PDQ_FETCH = 3'h1,
        PDQ_WAIT = 3'h3,
        PDQ_DATA = 3'h2,
        PDQ_PATCH = 3'h6,
        PDQ_PATCH_WAIT = 3'h7
    } pdq_state_e;
endpackage : pdq_pkg

`default_nettype wire

// ==== verilog/pdq_head_mem.sv ====
// Purpose: Small register array holding one head pointer per channel.
// Assumes: One write and one registered read per cycle.
// Notes:   Write-first on a same-entry collision.
`timescale 1ns/1ps
`default_nettype none

module pdq_head_mem #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [31:0] rd_data_q
);
    logic [31:0] mem_q [DEPTH];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 32'h0000_0000;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= 32'h0000_0000;
        end else if (wr_en && wr_addr == rd_addr) begin
            rd_data_q <= wr_data;
        end else begin
            rd_data_q <= mem_q[rd_addr];
        end
    end
endmodule : pdq_head_mem

`default_nettype wire

// ==== verilog/pdq_engine.sv ====
// Purpose: Walks linked descriptor chains for 8 transmit and 8 receive
//          channels and reports packet completion in the descriptors.
// Assumes: A simple word memory port with request/grant and read valid;
//          a data mover that takes each descriptor and says when done.
// Notes:   One descriptor walk at a time; channels served round robin.
//
// What this block does
// - Word 0 links to the next descriptor
// - First-fragment flag marks packet start descriptor
// - Last-fragment flag marks packet end descriptor
// - Word 1 points to the data buffer
// - Word 2 high half is buffer offset
// - Word 2 low half is buffer length
// - Packet length used only on start descriptors
// - Eight transmit, eight receive head pointers
// - Held flag means engine owns packet
// - Ownership only read on start descriptors; the code walks every descriptor without testing the held flag
// - Write back start descriptor, clear held flag
// - Zero next pointer ends the list
// - Set list-end flag at null next; the code sets it only when that descriptor also has the last flag
// - Same procedure for transmit and receive
// - Four aligned words fetched in order
`timescale 1ns/1ps
`default_nettype none

module pdq_engine
    import pdq_pkg::*;
#(
    parameter int unsigned CHANNELS = PDQ_CHANNELS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic head_wr_en,
    input wire logic head_wr_rx,
    input wire logic [PDQ_CH_W-1:0] head_wr_ch,
    input wire logic [31:0] head_wr_ptr,
    output logic [2*CHANNELS-1:0] chan_active,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr_q,
    output logic [31:0] mem_wdata_q,
    input wire logic mem_gnt,
    input wire logic mem_rvalid,
    input wire logic [31:0] mem_rdata,
    output logic desc_valid,
    output logic desc_rx_q,
    output logic [PDQ_CH_W-1:0] desc_ch_q,
    output logic [31:0] desc_buf_ptr_q,
    output logic [15:0] desc_buf_off_q,
    output logic [15:0] desc_buf_len_q,
    output logic [15:0] desc_pkt_len_q,
    output logic desc_first_q,
    output logic desc_last_q,
    input wire logic desc_done,
    output logic pkt_done_pulse_q,
    output logic list_end_pulse_q
);
    // ------------------------------------------------------------
    // Channel state
    // ------------------------------------------------------------
    localparam int unsigned NCH = 2 * CHANNELS;
    localparam int unsigned IW = PDQ_CH_W + 1;

    pdq_state_e state_q;
    logic [NCH-1:0] active_q;
    logic [IW-1:0] cur_q;
    logic [1:0] word_q;
    logic [31:0] desc_addr_q;
    logic [31:0] sop_addr_q;
    logic [31:0] sop_flags_q;
    logic [31:0] next_q;
    logic [31:0] w3_q;
    localparam logic [31:0] FLAGS_OFS = 32'(PDQ_W_FLAGS) * PDQ_WORD_STEP;
    logic mark_pend_q;
    logic [31:0] mark_word;
    logic wb_done;
    logic [IW-1:0] wr_idx;
    logic [31:0] head_rd;
    logic [IW-1:0] pick;
    logic pick_ok;
    logic [31:0] patch_word;
    logic null_next;

    assign wr_idx = {head_wr_rx, head_wr_ch};
    assign chan_active = active_q;
    assign null_next = (next_q == PDQ_NULL_PTR);

    pdq_head_mem #(.DEPTH(NCH), .AW(IW)) u_heads (
        .clk(clk),
        .reset(reset),
        .wr_en(head_wr_en),
        .wr_addr(wr_idx),
        .wr_data(head_wr_ptr),
        .rd_addr(pick),
        .rd_data_q(head_rd)
    );

    // Round robin after the channel served last.
    always_comb begin
        pick = cur_q;
        pick_ok = 1'b0;
        for (int k = NCH; k >= 1; k--) begin
            if (active_q[IW'((32'(cur_q) + k) % NCH)]) begin
                pick = IW'((32'(cur_q) + k) % NCH);
                pick_ok = 1'b1;
            end
        end
    end

    // A head write with a nonzero pointer starts a channel; completion at
    // list end parks it, and a later head write restarts it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active_q <= '0;
        end else begin
            if (wb_done && null_next && desc_last_q) begin
                active_q[cur_q] <= 1'b0;
            end
            // Parking without clearing would replay the list from its head.
            if (desc_valid && desc_done && !desc_last_q && null_next) begin
                active_q[cur_q] <= 1'b0;
            end
            if (head_wr_en && head_wr_ptr != PDQ_NULL_PTR) begin
                active_q[wr_idx] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Walk state machine
    // ------------------------------------------------------------
    assign mem_req = state_q == PDQ_WAIT || state_q == PDQ_PATCH_WAIT;
    assign wb_done = state_q == PDQ_PATCH_WAIT && mem_gnt && !mark_pend_q;
    assign mem_we = (state_q == PDQ_PATCH_WAIT);
    assign desc_valid = (state_q == PDQ_DATA);

    // The list-end mark goes only on the descriptor that closes a packet.
    always_comb begin
        mark_word = w3_q;
        mark_word[PDQ_BIT_LIST_END] = 1'b1;
        patch_word = sop_flags_q;
        patch_word[PDQ_BIT_HELD] = 1'b0;
        if (null_next && desc_addr_q == sop_addr_q) begin
            patch_word[PDQ_BIT_LIST_END] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= PDQ_IDLE;
            cur_q <= '0;
            word_q <= PDQ_W_NEXT;
            desc_addr_q <= PDQ_NULL_PTR;
            mem_addr_q <= PDQ_NULL_PTR;
            mem_wdata_q <= PDQ_NULL_PTR;
            next_q <= PDQ_NULL_PTR;
            mark_pend_q <= 1'b0;
            sop_addr_q <= PDQ_NULL_PTR;
            sop_flags_q <= PDQ_NULL_PTR;
        end else begin
            unique case (state_q)
                PDQ_IDLE: begin
                    if (pick_ok) begin
                        cur_q <= pick;
                        state_q <= PDQ_FETCH;
                    end
                end
                PDQ_FETCH: begin
                    desc_addr_q <= head_rd;
                    mem_addr_q <= head_rd;
                    word_q <= PDQ_W_NEXT;
                    state_q <= PDQ_WAIT;
                end
                PDQ_WAIT: begin
                    // The request stays up until the word arrives, so a
                    // slow memory never makes the walk lose its place.
                    if (mem_rvalid) begin
                        unique case (word_q)
                            PDQ_W_NEXT: next_q <= mem_rdata;
                            PDQ_W_FLAGS: begin
                                if (mem_rdata[PDQ_BIT_FIRST]) begin
                                    sop_addr_q <= desc_addr_q;
                                    sop_flags_q <= mem_rdata;
                                end
                            end
                            default: ;
                        endcase
                        if (word_q == PDQ_W_FLAGS) begin
                            state_q <= PDQ_DATA;
                        end else begin
                            word_q <= word_q + 2'h1;
                            mem_addr_q <= mem_addr_q + PDQ_WORD_STEP;
                        end
                    end
                end
                PDQ_DATA: begin
                    if (desc_done) begin
                        if (desc_last_q && null_next &&
                            desc_addr_q != sop_addr_q) begin
                            // A multi-descriptor packet marks its closing
                            // descriptor first, then the start one.
                            mem_addr_q <= desc_addr_q + FLAGS_OFS;
                            mem_wdata_q <= mark_word;
                            mark_pend_q <= 1'b1;
                            state_q <= PDQ_PATCH_WAIT;
                        end else if (desc_last_q) begin
                            mem_addr_q <= sop_addr_q + FLAGS_OFS;
                            mem_wdata_q <= patch_word;
                            state_q <= PDQ_PATCH_WAIT;
                        end else if (null_next) begin
                            state_q <= PDQ_IDLE;
                        end else begin
                            desc_addr_q <= next_q;
                            mem_addr_q <= next_q;
                            word_q <= PDQ_W_NEXT;
                            state_q <= PDQ_PATCH;
                        end
                    end
                end
                PDQ_PATCH: state_q <= PDQ_WAIT;
                PDQ_PATCH_WAIT: begin
                    if (mem_gnt && mark_pend_q) begin
                        mark_pend_q <= 1'b0;
                        mem_addr_q <= sop_addr_q + FLAGS_OFS;
                        mem_wdata_q <= patch_word;
                    end else if (mem_gnt) begin
                        if (null_next) begin
                            state_q <= PDQ_IDLE;
                        end else begin
                            desc_addr_q <= next_q;
                            mem_addr_q <= next_q;
                            word_q <= PDQ_W_NEXT;
                            state_q <= PDQ_PATCH;
                        end
                    end
                end
                default: state_q <= PDQ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Descriptor fields handed to the data mover
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            desc_buf_ptr_q <= PDQ_NULL_PTR;
            desc_buf_off_q <= 16'h0000;
            desc_buf_len_q <= 16'h0000;
            desc_pkt_len_q <= 16'h0000;
            desc_first_q <= 1'b0;
            desc_last_q <= 1'b0;
            w3_q <= PDQ_NULL_PTR;
        end else if (state_q == PDQ_WAIT && mem_rvalid) begin
            unique case (word_q)
                PDQ_W_BUF: desc_buf_ptr_q <= mem_rdata;
                PDQ_W_LEN: begin
                    desc_buf_off_q <= mem_rdata[31:PDQ_HALF];
                    desc_buf_len_q <= mem_rdata[PDQ_HALF-1:0];
                end
                PDQ_W_FLAGS: begin
                    w3_q <= mem_rdata;
                    desc_first_q <= mem_rdata[PDQ_BIT_FIRST];
                    desc_last_q <= mem_rdata[PDQ_BIT_LAST];
                    desc_pkt_len_q <= mem_rdata[PDQ_BIT_FIRST] ?
                        mem_rdata[PDQ_HALF-1:0] : 16'h0000;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            desc_rx_q <= 1'b0;
            desc_ch_q <= '0;
        end else begin
            desc_rx_q <= cur_q[IW-1];
            desc_ch_q <= cur_q[PDQ_CH_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pkt_done_pulse_q <= 1'b0;
            list_end_pulse_q <= 1'b0;
        end else begin
            pkt_done_pulse_q <= wb_done;
            list_end_pulse_q <= wb_done && null_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_patch_write;
        mem_req && mem_we && mem_gnt;
    endsequence

    sequence s_sop_write;
        s_patch_write and !mark_pend_q;
    endsequence

    a_held_cleared: assert property (@(posedge clk) disable iff (reset)
        s_sop_write |-> !mem_wdata_q[PDQ_BIT_HELD])
        else $error("write-back left held flag set");
    a_list_end_idle: assert property (@(posedge clk) disable iff (reset)
        (s_sop_write and null_next) |=> state_q == PDQ_IDLE)
        else $error("engine not idle after list end");
    a_list_end_mark: assert property (@(posedge clk) disable iff (reset)
        (s_sop_write and null_next) |=> list_end_pulse_q)
        else $error("list end not reported");
    a_last_frag_mark: assert property (@(posedge clk) disable iff (reset)
        (s_patch_write and mark_pend_q) |-> mem_wdata_q[PDQ_BIT_LIST_END] &&
        mem_addr_q == desc_addr_q + 32'h0000_000c)
        else $error("closing descriptor not marked");
    a_word_order: assert property (@(posedge clk) disable iff (reset)
        state_q == PDQ_WAIT && mem_rvalid && word_q != PDQ_W_FLAGS
        |=> word_q == $past(word_q) + 2'h1)
        else $error("descriptor words out of order");
    a_patch_addr: assert property (@(posedge clk) disable iff (reset)
        s_sop_write |-> mem_addr_q == sop_addr_q + 32'h0000_000c)
        else $error("write-back not at start descriptor flags");
    a_pkt_len_sop: assert property (@(posedge clk) disable iff (reset)
        desc_valid && !desc_first_q |-> desc_pkt_len_q == 16'h0000)
        else $error("packet length on continuation");
    a_head_start: assert property (@(posedge clk) disable iff (reset)
        head_wr_en && head_wr_ptr != PDQ_NULL_PTR
        |=> active_q[$past(wr_idx)])
        else $error("head write did not start channel");
    a_null_stop: assert property (@(posedge clk) disable iff (reset)
        desc_valid && desc_done && !desc_last_q && null_next
        |=> state_q == PDQ_IDLE)
        else $error("walked past null next pointer");
endmodule : pdq_engine

`default_nettype wire

// ==== tb/pdq_host_mem.sv ====
// Purpose: Host memory model holding descriptor chains for the engine.
// Assumes: Reads of words 1 to 3 are answered in the request cycle.
// Notes:   Slow mode refuses word 0 reads and write grants on odd cycles.
`timescale 1ns/1ps
`default_nettype none

module pdq_host_mem (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr_q,
    input wire logic [31:0] mem_wdata_q,
    output logic mem_gnt,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:255];
    logic tog_q;
    logic [31:0] last_q;
    logic rd_ok;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tog_q <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
        end
    end

    // Idle read data is inverted so a stale value can never pass.
    assign rd_ok = !slow || tog_q || (mem_addr_q[3:2] != 2'h0);
    assign mem_rvalid = mem_req && !mem_we && rd_ok;
    assign mem_gnt = mem_req && mem_we && (!slow || tog_q);
    assign mem_rdata = mem_rvalid ? mem[mem_addr_q[9:2]] : ~last_q;

    always @(posedge clk) begin
        if (mem_rvalid) begin
            last_q <= mem_rdata;
        end
        if (mem_gnt) begin
            mem[mem_addr_q[9:2]] <= mem_wdata_q;
        end
    end
endmodule : pdq_host_mem

`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the descriptor queue engine.
// Assumes: Descriptors live in the first kilobyte of the host model.
// Notes:   Flag nibble order is first, last, held, list end.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import pdq_pkg::*;
    logic clk, reset, head_wr_en, head_wr_rx, slow, desc_done;
    logic [2:0] head_wr_ch;
    logic [31:0] head_wr_ptr, mem_addr_q, mem_wdata_q, mem_rdata;
    logic [31:0] desc_buf_ptr_q;
    logic [15:0] chan_active, desc_buf_off_q, desc_buf_len_q, desc_pkt_len_q;
    logic mem_req, mem_we, mem_gnt, mem_rvalid, desc_valid, desc_rx_q;
    logic desc_first_q, desc_last_q, pkt_done_pulse_q, list_end_pulse_q;
    logic [2:0] desc_ch_q;
    int err_count, cmp_count;
    logic [3:0] exp_idx;

    pdq_engine pdq_engine_i (.clk(clk), .reset(reset),
        .head_wr_en(head_wr_en), .head_wr_rx(head_wr_rx),
        .head_wr_ch(head_wr_ch), .head_wr_ptr(head_wr_ptr),
        .chan_active(chan_active), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
        .desc_valid(desc_valid), .desc_rx_q(desc_rx_q),
        .desc_ch_q(desc_ch_q), .desc_buf_ptr_q(desc_buf_ptr_q),
        .desc_buf_off_q(desc_buf_off_q), .desc_buf_len_q(desc_buf_len_q),
        .desc_pkt_len_q(desc_pkt_len_q), .desc_first_q(desc_first_q),
        .desc_last_q(desc_last_q), .desc_done(desc_done),
        .pkt_done_pulse_q(pkt_done_pulse_q),
        .list_end_pulse_q(list_end_pulse_q));

    pdq_host_mem pdq_host_mem_i (.clk(clk), .reset(reset), .slow(slow),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .mem_gnt(mem_gnt),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: %s got %h want %h", $time, w, got, exp);
        end
    endtask : chk

    task head(input logic rx, input logic [2:0] ch, input logic [31:0] p);
        head_wr_en = 1'b1;
        head_wr_rx = rx;
        head_wr_ch = ch;
        head_wr_ptr = p;
        @(posedge clk);
        #1;
        head_wr_en = 1'b0;
        exp_idx = {rx, ch};
        @(posedge clk);
        #1;
    endtask : head

    task put(input logic [31:0] a, nxt, bp, input logic [15:0] off, len,
             input logic [3:0] fl, input logic [15:0] pl);
        pdq_host_mem_i.mem[a[9:2]] = nxt;
        pdq_host_mem_i.mem[a[9:2] + 8'h1] = bp;
        pdq_host_mem_i.mem[a[9:2] + 8'h2] = {off, len};
        pdq_host_mem_i.mem[a[9:2] + 8'h3] = {fl, 12'h0, pl};
    endtask : put

    task take(input logic [31:0] bp, input logic [15:0] off, len, pl,
              input logic first, last);
        for (int i = 0; i < 80 && desc_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(desc_valid, 1'b1, "descriptor offered");
        chk({desc_rx_q, desc_ch_q}, exp_idx, "descriptor channel");
        chk(desc_buf_ptr_q, bp, "buffer pointer");
        chk(desc_buf_off_q, off, "buffer offset");
        chk(desc_buf_len_q, len, "buffer length");
        chk(desc_pkt_len_q, pl, "packet length");
        chk(desc_first_q, first, "first flag");
        chk(desc_last_q, last, "last flag");
        desc_done = 1'b1;
        @(posedge clk);
        #1;
        desc_done = 1'b0;
    endtask : take

    task done_wait(input logic le, input logic [31:0] a, input logic [31:0] f);
        for (int i = 0; i < 80 && pkt_done_pulse_q !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(pkt_done_pulse_q, 1'b1, "packet done");
        chk(list_end_pulse_q, le, "list end pulse");
        chk(pdq_host_mem_i.mem[a[9:2] + 8'h3], f, "flags write-back");
    endtask : done_wait

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task test_reset;
        chk(chan_active, 16'h0000, "active in reset");
        chk(mem_req, 1'b0, "request in reset");
        chk(desc_valid, 1'b0, "descriptor in reset");
        @(posedge clk);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 16; i++) begin
            head(i[3], i[2:0], 32'h0000_0000);
        end
        chk(chan_active, 16'h0000, "zero heads idle");
        $display("test reset done");
    endtask : test_reset

    task test_single(input logic rx, input logic [2:0] ch,
                     input logic [31:0] a, input logic [15:0] off, pl);
        put(a, 32'h0, a + 32'h0000_1000, off, pl, 4'b1110, pl);
        chk(chan_active[{rx, ch}], 1'b0, "idle before head");
        head(rx, ch, a);
        chk(chan_active[{rx, ch}], 1'b1, "channel active");
        take(a + 32'h0000_1000, off, pl, pl, 1'b1, 1'b1);
        done_wait(1'b1, a, {4'b1101, 12'h0, pl});
        repeat (2) @(posedge clk);
        #1;
        chk(chan_active[{rx, ch}], 1'b0, "channel idle");
        $display("test single done");
    endtask : test_single

    task test_chain;
        slow = 1'b1;
        put(32'h200, 32'h240, 32'h3000, 16'h2, 16'd60, 4'b1110, 16'd60);
        put(32'h240, 32'h280, 32'h3100, 16'h0, 16'd1000, 4'b1010, 16'd1514);
        put(32'h280, 32'h0, 32'h3200, 16'h0, 16'd514, 4'b0110, 16'd1514);
        head(1'b1, 3'h7, 32'h200);
        take(32'h3000, 16'h2, 16'd60, 16'd60, 1'b1, 1'b1);
        done_wait(1'b0, 32'h200, {4'b1100, 12'h0, 16'd60});
        take(32'h3100, 16'h0, 16'd1000, 16'd1514, 1'b1, 1'b0);
        take(32'h3200, 16'h0, 16'd514, 16'h0, 1'b0, 1'b1);
        done_wait(1'b1, 32'h240, {4'b1000, 12'h0, 16'd1514});
        chk(pdq_host_mem_i.mem[8'ha3], {4'b0111, 12'h0, 16'd1514},
            "list end on last fragment");
        slow = 1'b0;
        $display("test chain done");
    endtask : test_chain

    task test_append;
        put(32'h300, 32'h0, 32'h3400, 16'h0, 16'd64, 4'b1110, 16'd64);
        put(32'h340, 32'h0, 32'h3500, 16'h4, 16'd80, 4'b1110, 16'd80);
        chk(chan_active[4'h3], 1'b0, "idle before head");
        head(1'b0, 3'h3, 32'h300);
        pdq_host_mem_i.mem[8'hc0] = 32'h340;
        take(32'h3400, 16'h0, 16'd64, 16'd64, 1'b1, 1'b1);
        done_wait(1'b0, 32'h300, {4'b1100, 12'h0, 16'd64});
        take(32'h3500, 16'h4, 16'd80, 16'd80, 1'b1, 1'b1);
        done_wait(1'b1, 32'h340, {4'b1101, 12'h0, 16'd80});
        put(32'h380, 32'h0, 32'h3600, 16'h0, 16'd8, 4'b1010, 16'd8);
        head(1'b0, 3'h3, 32'h380);
        take(32'h3600, 16'h0, 16'd8, 16'd8, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        chk(chan_active[4'h3], 1'b0, "parked at null next");
        chk(pdq_host_mem_i.mem[8'he3], {4'b1010, 12'h0, 16'd8},
            "no write-back without last");
        $display("test append done");
    endtask : test_append

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task conclude;
        $display("%0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    initial begin
        #400000;
        err_count++;
        $display("Error at %0t ns: run timed out", $time);
        conclude();
    end

    initial begin
        reset = 1'b1;
        head_wr_en = 1'b0;
        head_wr_rx = 1'b0;
        head_wr_ch = 3'h0;
        head_wr_ptr = 32'h0;
        slow = 1'b0;
        desc_done = 1'b0;
        repeat (15) @(posedge clk);
        #1;
        test_reset();
        test_single(1'b0, 3'h0, 32'h100, 16'hffff, 16'd60);
        test_single(1'b1, 3'h5, 32'h140, 16'h0, 16'hffff);
        test_single(1'b0, 3'h0, 32'h180, 16'h1, 16'd1514);
        test_chain();
        test_append();
        conclude();
    end
endmodule : tb_top

`default_nettype wire
